// File: verilog/cmp_sel_regs.sv
`timescale 1ns/1ps
// Purpose: Comparator input select, edge flag and output mirror registers
// Assumes: AXI4-Lite slave, one outstanding write and one read
// Notes:   Comparator 2 registers exist only when DUAL is 1
module cmp_sel_regs #(
  parameter bit DUAL = 1'b1
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // AXI4-Lite write address and data
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  // AXI4-Lite write response
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  output logic [1:0]                    s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  input  wire logic [7:0]               s_axi_araddr,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  // Comparator analog side
  input  wire logic [1:0]               comparator_result_bit,
  output logic [1:0]                    positive_input_select_1,
  output logic [1:0]                    negative_input_select_1,
  output logic [1:0]                    positive_input_select_2,
  output logic [1:0]                    negative_input_select_2,
  output logic [7:0]                    control_main_1,
  output logic [7:0]                    control_main_2,
  // Interrupt
  output logic                          irq
);
  import cmp_sel_pkg::*;

  function automatic logic [7:0] wmerge(input logic [7:0] old_v, input logic [7:0] wd,
                                        input logic [7:0] msk, input logic en);
    wmerge = en ? ((old_v & ~msk) | (wd & msk)) : old_v;
  endfunction

  function automatic logic mapped(input logic [7:0] a, input logic dual);
    case (a)
      ADDR_CTRL1_MAIN, ADDR_CTRL1_INPUTS, ADDR_OUT_MIRROR,
      ADDR_IRQ_STATUS, ADDR_IRQ_MASK: mapped = 1'b1;
      ADDR_CTRL2_MAIN, ADDR_CTRL2_INPUTS: mapped = dual;
      default: mapped = 1'b0;
    endcase
  endfunction

  localparam logic [7:0] IN_WMASK = DUAL ? INPUTS_WMASK_DUAL : INPUTS_WMASK_SINGLE;

  // Synchronised comparator outputs
  logic [1:0] res_sync;
  cmp_sync3 #(.WIDTH(2)) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (comparator_result_bit),
    .sync_out (res_sync)
  );

  // Register state
  logic [7:0] main1_r, main2_r, in1_r, in2_r;
  logic [7:0] main1_nxt, main2_nxt, in1_nxt, in2_nxt;
  logic [1:0] res_prev_r, res_prev_nxt;
  logic [1:0] flag_r, flag_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic       irq_r, irq_nxt;

  // Bus state
  wr_state_t  wst_r, wst_nxt;
  logic       aw_got_r, aw_got_nxt;
  logic       w_got_r, w_got_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic       rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  // Registered handshake and select outputs
  logic       awready_r, awready_nxt;
  logic       wready_r, wready_nxt;
  logic       bvalid_r, bvalid_nxt;
  logic       arready_r, arready_nxt;
  logic [1:0] isel1_r, isel1_nxt, nsel1_r, nsel1_nxt;
  logic [1:0] isel2_r, isel2_nxt, nsel2_r, nsel2_nxt;

  logic       do_write;
  logic       do_read;
  logic       wr_lane0;
  logic [1:0] rise_ev, fall_ev, edge_ev;
  logic [7:0] rd_val;

  always_comb begin
    do_write = (wst_r == WR_IDLE) && aw_got_r && w_got_r;
    do_read  = s_axi_arvalid && !rvalid_r;
    wr_lane0 = wstrb_r[0];
    for (int c = 0; c < 2; c++) begin
      rise_ev[c] = res_sync[c] && !res_prev_r[c];
      fall_ev[c] = !res_sync[c] && res_prev_r[c];
    end
    edge_ev[0] = (rise_ev[0] && in1_r[BIT_RISE_EN]) ||
                 (fall_ev[0] && in1_r[BIT_FALL_EN]);
    edge_ev[1] = DUAL && ((rise_ev[1] && in2_r[BIT_RISE_EN]) ||
                 (fall_ev[1] && in2_r[BIT_FALL_EN]));
  end

  // Read data mux
  always_comb begin
    rd_val = 8'h00;
    case (s_axi_araddr)
      ADDR_CTRL1_MAIN:   rd_val = main1_r;
      ADDR_CTRL1_INPUTS: rd_val = in1_r & IN_WMASK;
      ADDR_CTRL2_MAIN:   rd_val = DUAL ? main2_r : 8'h00;
      ADDR_CTRL2_INPUTS: rd_val = DUAL ? (in2_r & IN_WMASK) : 8'h00;
      ADDR_OUT_MIRROR:   rd_val = {6'h00, DUAL & res_sync[1], res_sync[0]};
      ADDR_IRQ_STATUS:   rd_val = {6'h00, flag_r};
      ADDR_IRQ_MASK:     rd_val = {6'h00, mask_r};
      default:           rd_val = 8'h00;
    endcase
  end

  // Register next state
  always_comb begin
    main1_nxt    = main1_r;
    main2_nxt    = main2_r;
    in1_nxt      = in1_r;
    in2_nxt      = in2_r;
    mask_nxt     = mask_r;
    res_prev_nxt = res_sync;
    flag_nxt     = flag_r;
    if (do_write) begin
      case (awaddr_r)
        ADDR_CTRL1_MAIN:   main1_nxt = wmerge(main1_r, wdata_r[7:0], MAIN_WMASK, wr_lane0);
        ADDR_CTRL1_INPUTS: in1_nxt = wmerge(in1_r, wdata_r[7:0], IN_WMASK, wr_lane0);
        ADDR_CTRL2_MAIN:   main2_nxt = wmerge(main2_r, wdata_r[7:0], MAIN_WMASK,
                                              wr_lane0 && DUAL);
        ADDR_CTRL2_INPUTS: in2_nxt = wmerge(in2_r, wdata_r[7:0], IN_WMASK, wr_lane0 && DUAL);
        ADDR_IRQ_MASK:     mask_nxt = wr_lane0 ? wdata_r[1:0] : mask_r;
        default: ;
      endcase
    end
    // Read of status clears; an edge in the same cycle wins
    if (do_read && s_axi_araddr == ADDR_IRQ_STATUS) begin
      flag_nxt = 2'b00;
    end
    flag_nxt = flag_nxt | edge_ev;
    if (!DUAL) begin
      flag_nxt[1] = 1'b0;
      mask_nxt[1] = 1'b0;
    end
    irq_nxt = |(flag_nxt & mask_nxt);
  end

  // Mux select outputs are registered so they stand glitch free
  always_comb begin
    isel1_nxt = in1_nxt[POS_SEL_LSB +: 2];
    isel2_nxt = in2_nxt[POS_SEL_LSB +: 2];
    // Single part: one select bit, 0 pin zero, 1 pin one
    nsel1_nxt = DUAL ? in1_nxt[NEG_SEL_LSB +: 2]
                     : {1'b0, in1_nxt[NEG_SEL_LSB]};
    nsel2_nxt = DUAL ? in2_nxt[NEG_SEL_LSB +: 2] : NEG_SEL_PIN0;
  end

  // Bus next state
  always_comb begin
    wst_nxt    = wst_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_awvalid && !aw_got_r && wst_r == WR_IDLE) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_r && wst_r == WR_IDLE) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    case (wst_r)
      WR_IDLE: begin
        if (do_write) begin
          wst_nxt    = WR_RESP;
          aw_got_nxt = 1'b0;
          w_got_nxt  = 1'b0;
          bresp_nxt  = mapped(awaddr_r, DUAL) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wst_nxt = WR_IDLE;
        end
      end
      default: wst_nxt = WR_IDLE;
    endcase
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (do_read) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {24'h000000, rd_val};
      rresp_nxt  = mapped(s_axi_araddr, DUAL) ? RESP_OKAY : RESP_SLVERR;
    end

    // Handshake outputs follow the next state, so a channel is refused
    // from the very edge at which it is taken, with no decode on the pins
    awready_nxt = !aw_got_nxt && (wst_nxt == WR_IDLE);
    wready_nxt  = !w_got_nxt && (wst_nxt == WR_IDLE);
    bvalid_nxt  = (wst_nxt == WR_RESP);
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      main1_r    <= RESET_CTRL;
      main2_r    <= RESET_CTRL;
      in1_r      <= RESET_CTRL;
      in2_r      <= RESET_CTRL;
      mask_r     <= RESET_IRQ;
      flag_r     <= RESET_IRQ;
      res_prev_r <= 2'h0;
      irq_r      <= 1'b0;
      isel1_r    <= 2'h0;
      isel2_r    <= 2'h0;
      nsel1_r    <= 2'h0;
      nsel2_r    <= 2'h0;
      wst_r      <= WR_IDLE;
      aw_got_r   <= 1'b0;
      w_got_r    <= 1'b0;
      awaddr_r   <= 8'h00;
      wdata_r    <= 32'h00000000;
      wstrb_r    <= 4'h0;
      bresp_r    <= RESP_OKAY;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h00000000;
      rresp_r    <= RESP_OKAY;
      // Slots are free out of reset, so the readies start high
      awready_r  <= 1'b1;
      wready_r   <= 1'b1;
      bvalid_r   <= 1'b0;
      arready_r  <= 1'b1;
    end else begin
      main1_r    <= main1_nxt;
      main2_r    <= main2_nxt;
      in1_r      <= in1_nxt;
      in2_r      <= in2_nxt;
      mask_r     <= mask_nxt;
      flag_r     <= flag_nxt;
      res_prev_r <= res_prev_nxt;
      irq_r      <= irq_nxt;
      isel1_r    <= isel1_nxt;
      isel2_r    <= isel2_nxt;
      nsel1_r    <= nsel1_nxt;
      nsel2_r    <= nsel2_nxt;
      wst_r      <= wst_nxt;
      aw_got_r   <= aw_got_nxt;
      w_got_r    <= w_got_nxt;
      awaddr_r   <= awaddr_nxt;
      wdata_r    <= wdata_nxt;
      wstrb_r    <= wstrb_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
      awready_r  <= awready_nxt;
      wready_r   <= wready_nxt;
      bvalid_r   <= bvalid_nxt;
      arready_r  <= arready_nxt;
    end
  end

  // Ready is high while the slot is free and, for writes, no response is pending, so each channel is taken alone
  assign s_axi_awready           = awready_r;
  assign s_axi_wready            = wready_r;
  assign s_axi_bvalid            = bvalid_r;
  assign s_axi_bresp             = bresp_r;
  assign s_axi_arready           = arready_r;
  assign s_axi_rvalid            = rvalid_r;
  assign s_axi_rdata             = rdata_r;
  assign s_axi_rresp             = rresp_r;
  assign positive_input_select_1 = isel1_r;
  assign positive_input_select_2 = isel2_r;
  assign negative_input_select_1 = nsel1_r;
  assign negative_input_select_2 = nsel2_r;
  assign control_main_1          = main1_r;
  assign control_main_2          = main2_r;
  assign irq                     = irq_r;
endmodule

// File: shared/cmp_sel_pkg.sv
// Purpose: Constants and types for the comparator input select register bank
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit registers in low bits
// Notes:   Overview list below describes what the bank must do
//
// Overview of operation
// - Falling edge of comparator result sets its flag when falling enable is set
// - Positive select in bits 5:4; code 10 picks fixed voltage reference
// - Two-comparator part: negative select bits 1:0, 00 pin zero, 01 pin one
// - Single-comparator part: one negative select bit, 0 pin zero, 1 pin one
// - Bits 3:2 of the inputs control register always read zero
// - Mirror shows comparator 1 at bit 0, comparator 2 at bit 1, rest zero
package cmp_sel_pkg;

  localparam logic [7:0] ADDR_CTRL1_MAIN   = 8'h00;
  localparam logic [7:0] ADDR_CTRL1_INPUTS = 8'h04;
  localparam logic [7:0] ADDR_CTRL2_MAIN   = 8'h08;
  localparam logic [7:0] ADDR_CTRL2_INPUTS = 8'h0C;
  localparam logic [7:0] ADDR_OUT_MIRROR   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h18;

  localparam int BIT_RISE_EN   = 7;
  localparam int BIT_FALL_EN   = 6;
  localparam int POS_SEL_LSB   = 4;
  localparam int NEG_SEL_LSB   = 0;

  localparam logic [7:0] INPUTS_WMASK_DUAL   = 8'hF3;
  localparam logic [7:0] INPUTS_WMASK_SINGLE = 8'hF1;
  localparam logic [7:0] MAIN_WMASK          = 8'hB7;
  localparam logic [7:0] RESET_CTRL          = 8'h00;
  localparam logic [1:0] RESET_IRQ           = 2'h0;

  localparam logic [1:0] POS_SEL_FVR  = 2'h2;
  localparam logic [1:0] NEG_SEL_PIN0 = 2'h0;
  localparam logic [1:0] NEG_SEL_PIN1 = 2'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;

endpackage

// File: verilog/cmp_sync3.sv
`timescale 1ns/1ps
// Purpose: Three-flop synchroniser for asynchronous comparator result levels
// Assumes: Input changes slower than two clock periods
// Notes:   Output changes only once stages two and three agree
module cmp_sync3 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
  logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt, out_nxt;

  always_comb begin
    s1_nxt  = async_in;
    s2_nxt  = s1_r;
    s3_nxt  = s2_r;
    out_nxt = out_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= s1_nxt;
      s2_r  <= s2_nxt;
      s3_r  <= s3_nxt;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;
endmodule

// File: tb/cmp_sel_chk.sv
// Purpose: Bus handshake and interrupt timing checks for the select bank
// Assumes: Bound to every cmp_sel_regs instance, dual or single
// Notes:   Select outputs may move only around a write response
`timescale 1ns/1ps
module cmp_sel_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Comparator side
  input wire logic [1:0]  positive_input_select_1,
  input wire logic [1:0]  negative_input_select_1,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_blk: assert property (p_ar_blk) else $error("read taken while answer pending");
  property p_w_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_blk: assert property (p_w_blk) else $error("write taken while response pending");
  property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  // A registered copy may trail the response by one clock
  property p_pos_sel; $changed(positive_input_select_1) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_pos_sel: assert property (p_pos_sel) else $error("positive select moved");
  property p_neg_sel; $changed(negative_input_select_1) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_neg_sel: assert property (p_neg_sel) else $error("negative select moved");
  property p_irq_hold;
    $fell(irq) |-> s_axi_rvalid || $past(s_axi_rvalid) || s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell on its own");
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// File: tb/tb.sv
// Purpose: Self-checking bench for the comparator select register bank
// Assumes: 25 MHz clock, dual and single variants share one bus, driven on rising edges
// Notes:   Comparator results are slow levels, given 8 clocks to settle
`timescale 1ns/1ps
module tb;
  import cmp_sel_pkg::*;
  logic        clk, rstn, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, comparator_result_bit;
  logic [1:0]  positive_input_select_1, negative_input_select_1;
  logic [1:0]  positive_input_select_2, negative_input_select_2;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, control_main_1, control_main_2;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  neg1_single;
  logic [31:0] rdata_single;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  cmp_sel_regs #(.DUAL(1'b1)) uut (.clk, .rstn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .comparator_result_bit, .positive_input_select_1, .negative_input_select_1,
    .positive_input_select_2, .negative_input_select_2, .control_main_1,
    .control_main_2, .irq);
  // Single-comparator variant rides on the same bus; its timing is identical
  cmp_sel_regs #(.DUAL(1'b0)) uut_single (.clk, .rstn, .s_axi_awvalid,
    .s_axi_awready(), .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready(), .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid(), .s_axi_bready, .s_axi_bresp(), .s_axi_arvalid,
    .s_axi_arready(), .s_axi_araddr, .s_axi_rvalid(), .s_axi_rready,
    .s_axi_rdata(rdata_single), .s_axi_rresp(), .comparator_result_bit,
    .positive_input_select_1(), .negative_input_select_1(neg1_single),
    .positive_input_select_2(), .negative_input_select_2(), .control_main_1(),
    .control_main_2(), .irq());
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      wrap_up;
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {24'h0, d};
    s_axi_bready  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1 && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !dd) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", s_axi_rdata, {24'h0, e});
    chk("rresp", s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask
  task t_reset;
    rd(ADDR_CTRL1_INPUTS, 8'h00, RESP_OKAY);
    rd(ADDR_CTRL2_INPUTS, 8'h00, RESP_OKAY);
    rd(ADDR_OUT_MIRROR, 8'h00, RESP_OKAY);
    chk("irq", irq, 32'h0);
    $display("test reset done");
  endtask
  task t_inputs;
    wr(ADDR_CTRL1_INPUTS, 8'hFF, RESP_OKAY);
    chk("neg1s", neg1_single, 32'h1);
    rd(ADDR_CTRL1_INPUTS, 8'hF3, RESP_OKAY);
    chk("rd1s", rdata_single, {24'h0, INPUTS_WMASK_SINGLE});
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL1_INPUTS, 8'h2C | 8'(i), RESP_OKAY);
      chk("pos1", positive_input_select_1, POS_SEL_FVR);
      chk("neg1", negative_input_select_1, 2'(i));
      chk("neg1s", neg1_single, 2'(i));
      wr(ADDR_CTRL2_INPUTS, 8'h2C | 8'(i), RESP_OKAY);
      chk("pos2", positive_input_select_2, POS_SEL_FVR);
      chk("neg2", negative_input_select_2, 2'(i));
      rd(ADDR_CTRL2_INPUTS, 8'h20 | 8'(i), RESP_OKAY);
    end
    $display("test inputs done");
  endtask
  task t_main;
    wr(ADDR_CTRL1_MAIN, 8'hFF, RESP_OKAY);
    chk("main1", control_main_1, {24'h0, MAIN_WMASK});
    rd(ADDR_CTRL1_MAIN, MAIN_WMASK, RESP_OKAY);
    wr(ADDR_CTRL2_MAIN, 8'hFF, RESP_OKAY);
    chk("main2", control_main_2, {24'h0, MAIN_WMASK});
    // Lane 0 strobe off: the write must leave the register alone
    s_axi_wstrb <= 4'hE;
    wr(ADDR_CTRL1_MAIN, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    chk("main1", control_main_1, {24'h0, MAIN_WMASK});
    $display("test main done");
  endtask
  task t_unmapped;
    wr(8'h1C, 8'h55, RESP_SLVERR);
    rd(8'h1C, 8'h00, RESP_SLVERR);
    $display("test unmapped done");
  endtask
  task t_mirror;
    for (int v = 0; v < 4; v++) begin
      comparator_result_bit <= 2'(v);
      repeat (8) @(posedge clk);
      rd(ADDR_OUT_MIRROR, 8'(v), RESP_OKAY);
      chk("mirror_s", rdata_single, 32'(v & 1));
    end
    $display("test mirror done");
  endtask
  task t_edge;
    wr(ADDR_IRQ_MASK, 8'h03, RESP_OKAY);
    wr(ADDR_CTRL1_INPUTS, 8'h40, RESP_OKAY);
    wr(ADDR_CTRL2_INPUTS, 8'h00, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, 8'h00, RESP_OKAY);
    comparator_result_bit <= 2'b00;
    repeat (8) @(posedge clk);
    chk("irq", irq, 32'h1);
    comparator_result_bit <= 2'b01;
    repeat (8) @(posedge clk);
    comparator_result_bit <= 2'b00;
    repeat (8) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 8'h01, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", irq, 32'h0);
    comparator_result_bit <= 2'b01;
    repeat (8) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 8'h00, RESP_OKAY);
    // Masked flag must still be recorded
    wr(ADDR_IRQ_MASK, 8'h00, RESP_OKAY);
    comparator_result_bit <= 2'b00;
    repeat (8) @(posedge clk);
    chk("irq", irq, 32'h0);
    rd(ADDR_IRQ_STATUS, 8'h01, RESP_OKAY);
    // Second comparator: rising then falling edge, both enabled
    wr(ADDR_IRQ_MASK, 8'h02, RESP_OKAY);
    wr(ADDR_CTRL2_INPUTS, 8'hC0, RESP_OKAY);
    comparator_result_bit <= 2'b10;
    repeat (8) @(posedge clk);
    chk("irq", irq, 32'h1);
    rd(ADDR_IRQ_STATUS, 8'h02, RESP_OKAY);
    comparator_result_bit <= 2'b00;
    repeat (8) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 8'h02, RESP_OKAY);
    $display("test edge done");
  endtask
  initial begin
    rstn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    comparator_result_bit = 2'b00;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_inputs;
    t_main;
    t_unmapped;
    t_mirror;
    t_edge;
    wrap_up;
  end
endmodule
bind cmp_sel_regs cmp_sel_chk chk (.clk, .rstn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .positive_input_select_1,
  .negative_input_select_1, .irq);
